// File: crsse_exec.sv
// execution unit for returns, stores, sign extension, shifts, cache
// writes and xor, with registers on an Avalon-MM slave
// assumes stores finish when mem_ack rises while mem_req is high
//
// Functional notes
// - break return jumps to A plus sext immediate, then clears break flag.
// - break return runs one delay-slot op first; breaks stay off in it.
// - interrupt return jumps to A plus sext immediate, then sets IE.
// - interrupt return runs the delay-slot op with interrupts still off.
// - subroutine return jumps after the delay slot; status flags unchanged.
// - byte store writes the low byte of D at A plus B.
// - immediate stores address A plus the sign-extended 16-bit immediate.
// - halfword store clears the address lsb and writes D's low half.
// - word store clears two address lsbs and writes all of D.
// - halfword sign extension copies bit 15 into the upper half.
// - byte sign extension copies bit 7 into the upper 24 bits.
// - arithmetic shift right keeps the sign bit in the msb.
// - every right shift loads carry with the lsb shifted out.
// - shift through carry puts old carry in the msb.
// - logical shift right puts zero in the msb.
// - data cache write: A is tag with valid and lock, B is data.
// - data cache write only acts while the data cache is disabled.
// - instruction cache write: A is tag with valid and lock, B is data.
// - instruction cache write only acts while that cache is disabled.
// - register xor writes A xor B and leaves carry alone.
// - immediate xor extension is selectable; sign extension by default.
`timescale 1ns/10ps
`default_nettype none

module crsse_exec
  import crsse_pkg::*;
#(
  parameter bit XORI_SIGN_EXT = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // data memory store port
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic      [1:0]  mem_size,
  input  wire logic        mem_ack,
  // cache write ports
  output logic             dcache_wr,
  output logic             icache_wr,
  output logic      [31:0] cache_tag,
  output logic             cache_valid,
  output logic             cache_lock,
  output logic      [31:0] cache_data,
  // processor status
  output logic      [31:0] pc,
  output logic             branch_taken,
  output logic             carry_flag,
  output logic             break_enable,
  output logic             interrupt_enable_flag
);

  // a select of this flag wider than one bit has no meaning
  if (XORI_SIGN_EXT !== 1'b0 && XORI_SIGN_EXT !== 1'b1) begin : g_chk
    $error("XORI_SIGN_EXT must be 0 or 1");
  end

  typedef struct packed {
    crsse_fsm_t  fsm;
    logic [4:0]  op;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opd;
    logic [15:0] imm;
    logic        carry;
    logic        break_in_progress_flag;
    logic        ie;
    logic        dce;
    logic        ice;
    logic [31:0] pc;
    logic [31:0] result;
    logic [31:0] target;
    logic [31:0] st_addr;
    logic [31:0] st_data;
    logic [1:0]  st_size;
    logic [1:0]  slot;
    logic        slot_run;
    logic        illegal;
    logic        refused;
    logic [31:0] rdata;
    logic        rd_ack;
    logic        dc_wr;
    logic        ic_wr;
    logic [31:0] c_tag;
    logic [31:0] c_data;
    logic        branch;
  } crsse_state_t;

  crsse_state_t s_q;
  crsse_state_t s_d;
  logic         rst_meta_q;
  logic         rst_n;
  logic         busy;
  logic         finish;
  logic [31:0]  sum_ab;
  logic [31:0] ea_imm;
  logic [31:0] xori_ext;

  // reset asserts at once but releases two edges later
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // operand arithmetic shared by the stores, returns and immediate xor
  assign busy     = (s_q.fsm != ST_IDLE);
  assign sum_ab   = s_q.opa + s_q.opb;
  assign ea_imm   = s_q.opa + crsse_sign_extend_half_op(s_q.imm);
  assign xori_ext = XORI_SIGN_EXT ? crsse_sign_extend_half_op(s_q.imm)
                                  : {16'h0000, s_q.imm};

  // next-state logic: bus slave, operation execution, slot retirement
  always_comb begin
    s_d         = s_q;
    s_d.rd_ack  = 1'b0;
    s_d.dc_wr   = 1'b0;
    s_d.ic_wr   = 1'b0;
    s_d.branch  = 1'b0;
    finish      = 1'b0;
    case (s_q.fsm)
      ST_IDLE: begin
        if (avs_write) begin
          case (avs_address)
            REG_CTRL: begin
              s_d.op       = avs_writedata[4:0];
              s_d.fsm      = ST_EXEC;
              s_d.slot_run = (s_q.slot != SLOT_NONE);
            end
            REG_OPA: s_d.opa = avs_writedata;
            REG_OPB: s_d.opb = avs_writedata;
            REG_OPD: s_d.opd = avs_writedata;
            REG_IMM: s_d.imm = avs_writedata[15:0];
            REG_MSR: begin
              s_d.carry = avs_writedata[MSR_C];
              s_d.break_in_progress_flag   = avs_writedata[MSR_BIP];
              s_d.ie    = avs_writedata[MSR_IE];
              s_d.dce   = avs_writedata[MSR_DCE];
              s_d.ice   = avs_writedata[MSR_ICE];
            end
            REG_STATUS: begin
              // write one to clear; nothing sets these while idle
              s_d.illegal = s_q.illegal & ~avs_writedata[STS_ILL];
              s_d.refused = s_q.refused & ~avs_writedata[STS_REF];
            end
            default: ;
          endcase
        end
        // reads take one wait cycle so read data leave a flip-flop
        if (avs_read && !s_q.rd_ack) begin
          s_d.rd_ack = 1'b1;
          s_d.rdata  = '0;
          case (avs_address)
            REG_CTRL:   s_d.rdata[4:0]  = s_q.op;
            REG_OPA:    s_d.rdata       = s_q.opa;
            REG_OPB:    s_d.rdata       = s_q.opb;
            REG_OPD:    s_d.rdata       = s_q.opd;
            REG_IMM:    s_d.rdata[15:0] = s_q.imm;
            REG_MSR: begin
              s_d.rdata[MSR_C]   = s_q.carry;
              s_d.rdata[MSR_BIP] = s_q.break_in_progress_flag;
              s_d.rdata[MSR_IE]  = s_q.ie;
              s_d.rdata[MSR_DCE] = s_q.dce;
              s_d.rdata[MSR_ICE] = s_q.ice;
            end
            REG_RESULT: s_d.rdata       = s_q.result;
            REG_PC:     s_d.rdata       = s_q.pc;
            REG_STADDR: s_d.rdata       = s_q.st_addr;
            REG_STDATA: s_d.rdata       = s_q.st_data;
            REG_STATUS: begin
              s_d.rdata[STS_BUSY] = busy;
              s_d.rdata[STS_SLOT] = (s_q.slot != SLOT_NONE);
              s_d.rdata[STS_ILL]  = s_q.illegal;
              s_d.rdata[STS_REF]  = s_q.refused;
            end
            REG_TARGET: s_d.rdata       = s_q.target;
            default:    s_d.rdata       = '0;
          endcase
        end
      end
      ST_EXEC: begin
        // operands use sv numbering: printed bit k is sv bit 31-k
        case (s_q.op)
          OP_RTBD, OP_RTID, OP_RTSD: begin
            if (s_q.slot_run) begin
              // a return inside a delay slot is not served
              s_d.illegal = 1'b1;
              finish      = 1'b1;
            end else begin
              s_d.target = ea_imm;
              s_d.pc     = s_q.pc + PC_STEP;
              s_d.fsm    = ST_IDLE;
              if (s_q.op == OP_RTBD) begin
                s_d.slot = SLOT_BRK;
              end else if (s_q.op == OP_RTID) begin
                s_d.slot = SLOT_INT;
              end else begin
                s_d.slot = SLOT_SUB;
              end
            end
          end
          OP_SB, OP_SBI: begin
            s_d.st_addr = (s_q.op == OP_SB) ? sum_ab : ea_imm;
            s_d.st_data = {24'h000000, s_q.opd[7:0]};
            s_d.st_size = SIZE_BYTE;
            s_d.fsm     = ST_STORE;
          end
          OP_SH, OP_SHI: begin
            s_d.st_addr    = (s_q.op == OP_SH) ? sum_ab : ea_imm;
            s_d.st_addr[0] = 1'b0;
            s_d.st_data    = {16'h0000, s_q.opd[15:0]};
            s_d.st_size    = SIZE_HALF;
            s_d.fsm        = ST_STORE;
          end
          OP_SW, OP_SWI: begin
            s_d.st_addr      = (s_q.op == OP_SW) ? sum_ab : ea_imm;
            s_d.st_addr[1:0] = 2'h0;
            s_d.st_data      = s_q.opd;
            s_d.st_size      = SIZE_WORD;
            s_d.fsm          = ST_STORE;
          end
          OP_SIGN_EXTEND_HALF_OP: begin
            s_d.result = {{16{s_q.opa[15]}}, s_q.opa[15:0]};
            finish     = 1'b1;
          end
          OP_SIGN_EXTEND_BYTE_OP: begin
            s_d.result = {{24{s_q.opa[7]}}, s_q.opa[7:0]};
            finish     = 1'b1;
          end
          OP_SRA: begin
            s_d.result = {s_q.opa[31], s_q.opa[31:1]};
            s_d.carry  = s_q.opa[0];
            finish     = 1'b1;
          end
          OP_SRC: begin
            s_d.result = {s_q.carry, s_q.opa[31:1]};
            s_d.carry  = s_q.opa[0];
            finish     = 1'b1;
          end
          OP_SRL: begin
            s_d.result = {1'b0, s_q.opa[31:1]};
            s_d.carry  = s_q.opa[0];
            finish     = 1'b1;
          end
          OP_WDC, OP_WIC: begin
            // writing a live cache would race its own refills
            if (s_q.op == OP_WDC ? !s_q.dce : !s_q.ice) begin
              s_d.dc_wr  = (s_q.op == OP_WDC);
              s_d.ic_wr  = (s_q.op == OP_WIC);
              s_d.c_tag  = s_q.opa;
              s_d.c_data = s_q.opb;
            end else begin
              s_d.refused = 1'b1;
            end
            finish = 1'b1;
          end
          OP_XOR: begin
            s_d.result = s_q.opa ^ s_q.opb;
            finish     = 1'b1;
          end
          OP_XORI: begin
            s_d.result = s_q.opa ^ xori_ext;
            finish     = 1'b1;
          end
          default: begin
            s_d.illegal = 1'b1;
            finish      = 1'b1;
          end
        endcase
      end
      ST_STORE: begin
        if (mem_ack) begin
          finish = 1'b1;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase
    // retire: the delay slot done, the pending return finally acts
    if (finish) begin
      s_d.fsm      = ST_IDLE;
      s_d.slot_run = 1'b0;
      if (s_q.slot_run) begin
        s_d.pc     = s_q.target;
        s_d.branch = 1'b1;
        s_d.slot   = SLOT_NONE;
        if (s_q.slot == SLOT_BRK) begin
          s_d.break_in_progress_flag = 1'b0;
        end
        if (s_q.slot == SLOT_INT) begin
          s_d.ie = 1'b1;
        end
      end else begin
        s_d.pc = s_q.pc + PC_STEP;
      end
    end
  end

  // the whole state in one register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // port drive; waitrequest is combinational, data from flops
  assign avs_waitrequest       = busy | (avs_read & ~s_q.rd_ack);
  assign avs_readdata          = s_q.rdata;
  assign mem_req               = (s_q.fsm == ST_STORE);
  assign mem_addr              = s_q.st_addr;
  assign mem_wdata             = s_q.st_data;
  assign mem_size              = s_q.st_size;
  assign dcache_wr             = s_q.dc_wr;
  assign icache_wr             = s_q.ic_wr;
  assign cache_tag             = s_q.c_tag;
  assign cache_valid           = s_q.c_tag[1]; // printed bit 30
  assign cache_lock            = s_q.c_tag[0]; // printed bit 31
  assign cache_data            = s_q.c_data;
  assign pc                    = s_q.pc;
  assign branch_taken          = s_q.branch;
  assign carry_flag            = s_q.carry;
  assign break_enable          = ~s_q.break_in_progress_flag;
  assign interrupt_enable_flag = s_q.ie;

  // checks
  logic exec_q;
  assign exec_q = (s_q.fsm == ST_EXEC);

  property p_ret_target;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && !s_q.slot_run && s_q.op == OP_RTBD
      |=> s_q.slot == SLOT_BRK && s_q.target == $past(ea_imm);
  endproperty
  a_ret_target: assert property (p_ret_target)
    else $error("break return target or slot kind wrong");

  property p_brk_slot;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && s_q.slot_run && s_q.slot == SLOT_BRK
      |=> !s_q.break_in_progress_flag && branch_taken && s_q.pc == $past(s_q.target);
  endproperty
  a_brk_slot: assert property (p_brk_slot)
    else $error("break flag or branch wrong after delay slot");

  property p_ie_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    s_q.slot == SLOT_INT && !finish
      && !(avs_write && !busy && avs_address == REG_MSR)
      |=> s_q.ie == $past(s_q.ie);
  endproperty
  a_ie_hold: assert property (p_ie_hold)
    else $error("interrupt enable changed before slot retired");

  property p_ie_set;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && s_q.slot_run && s_q.slot == SLOT_INT
      |=> s_q.ie && branch_taken ##1 !branch_taken;
  endproperty
  a_ie_set: assert property (p_ie_set)
    else $error("interrupt enable not set after slot");

  property p_sub_flags;
    @(posedge clk_sys) disable iff (!rst_n)
    finish && s_q.slot_run && s_q.slot == SLOT_SUB
      |=> $stable(s_q.break_in_progress_flag) && $stable(s_q.ie) && branch_taken;
  endproperty
  a_sub_flags: assert property (p_sub_flags)
    else $error("subroutine return disturbed status flags");

  property p_sb;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_SB |=> mem_req && mem_addr == $past(sum_ab)
      && mem_wdata[7:0] == $past(s_q.opd[7:0]) && mem_size == SIZE_BYTE;
  endproperty
  a_sb: assert property (p_sb)
    else $error("byte store address or data wrong");

  property p_shi;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_SHI |=> mem_req && !mem_addr[0]
      && mem_addr[31:1] == $past(ea_imm[31:1])
      && mem_wdata[15:0] == $past(s_q.opd[15:0]);
  endproperty
  a_shi: assert property (p_shi)
    else $error("halfword immediate store wrong");

  property p_sw;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && (s_q.op == OP_SW || s_q.op == OP_SWI)
      |=> mem_addr[1:0] == 2'h0 && mem_wdata == $past(s_q.opd);
  endproperty
  a_sw: assert property (p_sw)
    else $error("word store not aligned or data wrong");

  property p_sext;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_SIGN_EXTEND_BYTE_OP
      |=> s_q.result == {{24{$past(s_q.opa[7])}}, $past(s_q.opa[7:0])};
  endproperty
  a_sext: assert property (p_sext)
    else $error("byte sign extension wrong");

  property p_shift;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_SRC |=> carry_flag == $past(s_q.opa[0])
      && s_q.result[31] == $past(s_q.carry);
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift through carry wrong");

  property p_wdc;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_WDC |=> dcache_wr == !$past(s_q.dce)
      && !icache_wr;
  endproperty
  a_wdc: assert property (p_wdc)
    else $error("data cache write gated wrongly");

  property p_xor;
    @(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_XOR |=> $stable(s_q.carry)
      && s_q.result == ($past(s_q.opa) ^ $past(s_q.opb));
  endproperty
  a_xor: assert property (p_xor)
    else $error("register xor wrong");

  c_store: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mem_req && mem_ack);
  c_brk: cover property (@(posedge clk_sys) disable iff (!rst_n)
    finish && s_q.slot_run && s_q.slot == SLOT_BRK);
  c_refuse: cover property (@(posedge clk_sys) disable iff (!rst_n)
    exec_q && s_q.op == OP_WIC && s_q.ice);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    avs_read && !avs_waitrequest);

endmodule

`default_nettype wire

// File: crsse_pkg.sv
// constants, state encodings and helpers for the return/store/shift unit
// assumes a single 20 MHz clock domain and 32-bit Avalon-MM data
package crsse_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_OPA    = 6'h04;
  localparam logic [5:0] REG_OPB    = 6'h08;
  localparam logic [5:0] REG_OPD    = 6'h0C;
  localparam logic [5:0] REG_IMM    = 6'h10;
  localparam logic [5:0] REG_MSR    = 6'h14;
  localparam logic [5:0] REG_RESULT = 6'h18;
  localparam logic [5:0] REG_PC     = 6'h1C;
  localparam logic [5:0] REG_STADDR = 6'h20;
  localparam logic [5:0] REG_STDATA = 6'h24;
  localparam logic [5:0] REG_STATUS = 6'h28;
  localparam logic [5:0] REG_TARGET = 6'h2C;

  // machine status register field positions (sv numbering, 0 = lsb)
  localparam int MSR_C   = 0;
  localparam int MSR_BIP = 1;
  localparam int MSR_IE  = 2;
  localparam int MSR_DCE = 3;
  localparam int MSR_ICE = 4;

  // status register field positions
  localparam int STS_BUSY = 0;
  localparam int STS_SLOT = 1;
  localparam int STS_ILL  = 2;
  localparam int STS_REF  = 3;

  // operation codes written to the control register
  localparam logic [4:0] OP_RTBD   = 5'h00;
  localparam logic [4:0] OP_RTID   = 5'h01;
  localparam logic [4:0] OP_RTSD   = 5'h02;
  localparam logic [4:0] OP_SB     = 5'h03;
  localparam logic [4:0] OP_SBI    = 5'h04;
  localparam logic [4:0] OP_SH     = 5'h05;
  localparam logic [4:0] OP_SHI    = 5'h06;
  localparam logic [4:0] OP_SW     = 5'h07;
  localparam logic [4:0] OP_SWI    = 5'h08;
  localparam logic [4:0] OP_SIGN_EXTEND_HALF_OP = 5'h09;
  localparam logic [4:0] OP_SIGN_EXTEND_BYTE_OP  = 5'h0A;
  localparam logic [4:0] OP_SRA    = 5'h0B;
  localparam logic [4:0] OP_SRC    = 5'h0C;
  localparam logic [4:0] OP_SRL    = 5'h0D;
  localparam logic [4:0] OP_WDC    = 5'h0E;
  localparam logic [4:0] OP_WIC    = 5'h0F;
  localparam logic [4:0] OP_XOR    = 5'h10;
  localparam logic [4:0] OP_XORI   = 5'h11;

  // store access sizes on the memory port
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // pending delay-slot kinds
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_BRK  = 2'h1;
  localparam logic [1:0] SLOT_INT  = 2'h2;
  localparam logic [1:0] SLOT_SUB  = 2'h3;

  // sequential instruction step
  localparam logic [31:0] PC_STEP = 32'h0000_0004;

  // gray coded along idle -> exec -> store
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_EXEC  = 2'h1,
    ST_STORE = 2'h3
  } crsse_fsm_t;

  // sign-extend a 16-bit immediate to a word
  function automatic logic [31:0] crsse_sign_extend_half_op(input logic [15:0] v);
    crsse_sign_extend_half_op = {{16{v[15]}}, v};
  endfunction

endpackage

// File: crsse_mem_model.sv
// store-side partner: acks each store after a chosen delay, keeps the last
// assumes one store at a time, request held until the ack edge
`timescale 1ns/10ps
`default_nettype none
module crsse_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // store port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  output logic             mem_ack,
  // bench side
  input  wire logic [1:0]  dly,
  output logic      [31:0] l_addr,
  output logic      [31:0] l_data,
  output logic      [1:0]  l_size,
  output int               n_st
);
  logic [1:0] cnt;
  // ack waits dly cycles so both prompt and slow answers occur
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      n_st <= 0;
    end else if (mem_req && mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      n_st <= n_st + 1;
      l_addr <= mem_addr;
      l_data <= mem_wdata;
      l_size <= mem_size;
    end else if (mem_req && cnt >= dly) begin
      mem_ack <= 1'b1;
    end else if (mem_req) begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: crsse_exec_bench.sv
// self-checking bench for the return/store/shift unit
// assumes registers reached over avalon-mm, stores acked by the mem model
`timescale 1ns/10ps
`default_nettype none
module crsse_exec_bench;
  import crsse_pkg::*;
  logic clk_sys, nrst, avs_read, avs_write, mem_ack, dcache_wr, icache_wr;
  logic cache_valid, cache_lock, branch_taken, carry_flag, break_enable;
  logic interrupt_enable_flag, avs_waitrequest, mem_req, c;
  logic [5:0] avs_address;
  logic [1:0] mem_size, dly, l_size, ck;
  logic [31:0] avs_writedata, avs_readdata, mem_addr, mem_wdata, cache_tag;
  logic [31:0] cache_data, pc, l_addr, l_data, q, a, b, d, t, ct, cd;
  logic [15:0] im;
  logic [4:0] op;
  int n_fail, checks, n_st, nd;
  int n_cw = 0;
  int n_br = 0;

  crsse_exec crsse_exec_i (.clk_sys, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_req,
    .mem_addr, .mem_wdata, .mem_size, .mem_ack, .dcache_wr, .icache_wr,
    .cache_tag, .cache_valid, .cache_lock, .cache_data, .pc, .branch_taken,
    .carry_flag, .break_enable, .interrupt_enable_flag);
  crsse_mem_model crsse_mem_model_i (.clk_sys, .nrst, .mem_req, .mem_addr,
    .mem_wdata, .mem_size, .mem_ack, .dly, .l_addr, .l_data, .l_size, .n_st);

  // cache write and branch pulses last one cycle, so catch them at the edge
  always @(posedge clk_sys) begin
    if (branch_taken === 1'b1) begin
      n_br <= n_br + 1;
    end
    if (dcache_wr === 1'b1 || icache_wr === 1'b1) begin
      n_cw <= n_cw + 1;
      ck <= {icache_wr, dcache_wr};
      ct <= cache_tag;
      cd <= cache_data;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] ad,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= wd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // start an op, then a status read stalls until it has finished
  task automatic go(input logic [4:0] o);
    bus(1'b1, REG_CTRL, {27'h0, o});
    bus(1'b0, REG_STATUS, 32'h0);
  endtask

  function automatic logic [31:0] fx(input logic [4:0] o);
    case (o)
      OP_SIGN_EXTEND_HALF_OP: fx = {{16{a[15]}}, a[15:0]};
      OP_SIGN_EXTEND_BYTE_OP:  fx = {{24{a[7]}}, a[7:0]};
      OP_SRA:    fx = {a[31], a[31:1]};
      OP_SRC:    fx = {c, a[31:1]};
      OP_SRL:    fx = {1'b0, a[31:1]};
      OP_XOR:    fx = a ^ b;
      default:   fx = a ^ {{16{im[15]}}, im};
    endcase
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // watchdog at 40000 cycles, well beyond the under one thousand cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {nrst, avs_read, avs_write, dly} = '0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    {n_fail, checks} = '0;
    void'($urandom(32'h36E430D8));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    bus(1'b0, REG_MSR, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 6'h30, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      // first pass is a hand-picked corner: every sign bit of a, d and im set
      a = (i == 0) ? 32'h8000_8081 : $urandom;
      b = $urandom;
      d = (i == 0) ? 32'h8000_FFFF : $urandom;
      t = $urandom;
      im = (i == 0) ? 16'h8000 : t[15:0];
      dly <= t[17:16];
      bus(1'b1, REG_OPA, a);
      bus(1'b1, REG_OPB, b);
      bus(1'b1, REG_OPD, d);
      bus(1'b1, REG_IMM, {16'h0, im});
      for (int j = 0; j < 7; j++) begin
        op = (j < 5) ? OP_SIGN_EXTEND_HALF_OP + 5'(j) : OP_XOR + 5'(j - 5);
        c = t[j];
        bus(1'b1, REG_MSR, {31'h0, c});
        go(op);
        bus(1'b0, REG_RESULT, 32'h0);
        chk(q, fx(op));
        chk({31'h0, carry_flag}, {31'h0, (j > 1 && j < 5) ? a[0] : c});
      end
      for (int j = 0; j < 6; j++) begin
        nd = n_st;
        go(OP_SB + 5'(j));
        t = j[0] ? a + {{16{im[15]}}, im} : a + b;
        chk(l_addr, t & ~((32'h1 << (j / 2)) - 32'h1));
        chk(l_data, d & ((32'h1 << (8 << (j / 2))) - 32'h1));
        chk({30'h0, l_size}, 32'(j / 2));
        chk(32'(n_st - nd), 32'h1);
      end
      $display("test ops pass %0d done", i);
    end
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, REG_MSR, 32'h3);
      go(OP_RTBD + 5'(k));
      chk({31'h0, (k == 0) ? break_enable : interrupt_enable_flag}, 0);
      nd = n_br;
      go(OP_XOR);
      chk(32'(n_br - nd), 32'h1);
      bus(1'b0, REG_RESULT, 32'h0);
      chk(q, a ^ b);
      chk(pc, a + {{16{im[15]}}, im});
      bus(1'b0, REG_MSR, 32'h0);
      chk(q, (k == 0) ? 32'h1 : (k == 1) ? 32'h7 : 32'h3);
    end
    $display("test returns done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, REG_MSR, k[1] ? (k[0] ? 32'h10 : 32'h08) : 32'h0);
      nd = n_cw;
      go(k[0] ? OP_WIC : OP_WDC);
      chk(q, k[1] ? 32'h8 : 32'h0);
      chk(32'(n_cw - nd), k[1] ? 32'h0 : 32'h1);
      if (!k[1]) begin
        chk({30'h0, ck}, k[0] ? 32'h2 : 32'h1);
        chk(ct, a);
        chk(cd, b);
        chk({30'h0, cache_valid, cache_lock}, {30'h0, a[1:0]});
      end
    end
    $display("test cache writes done");
    end_of_test();
  end
endmodule
`default_nettype wire
